/* src/scs_pkg.sv */
// Shared constants and types for the system clock sync unit
package scs_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 50000000;
    // Time of day kept in milliseconds since midnight
    localparam int TIME_W = 32;
    localparam logic [31:0] MS_PER_DAY = 32'h0526_5C00;
    localparam logic [31:0] MS_PER_MIN = 32'h0000_EA60;
    localparam logic [31:0] HALF_MIN_MS = 32'h0000_7530;
    // One millisecond in cycles
    localparam int unsigned MS_TICK_NS = 1000000;
    localparam int unsigned MS_TICK_CYC = MS_TICK_NS / (1000000000 / CLK_HZ);
    // Sync loss timeout: 1.5 minutes in milliseconds
    localparam logic [31:0] SYNC_TMO_MS = 32'h0001_5F90;
    // Backward step limit: four seconds
    localparam logic [31:0] NO_STEP_BACK_MS = 32'h0000_0FA0;
    // Filtered deviation clamp, +-125 ms
    localparam logic signed [31:0] FILT_LIM_MS = 32'sh0000_007D;
    // Filter weight as a right shift (1/4 of previous deviation)
    localparam int FILT_SHIFT = 2;
    // Reset values
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    localparam logic [15:0] AA_RST = 16'h0000;
    // Pulse input select encoding
    localparam logic [1:0] PSEL_NONE = 2'h0;
    localparam logic [1:0] PSEL_DI = 2'h1;
    localparam logic [1:0] PSEL_VI = 2'h2;
    localparam logic [1:0] PSEL_VO = 2'h3;
    // Sync source indicator codes
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'h0,
        SRC_PULSE = 2'h1,
        SRC_PROTOCOL = 2'h2
    } scs_src_t;
    // Update sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DEV = 3'h2,
        ST_APPLY = 3'h4
    } scs_state_t;
endpackage

/* src/scs_sync2.sv */
// Two-stage synchroniser bank for asynchronous inputs
`timescale 1ns/10ps
module scs_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Asynchronous in, synchronised out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    // First stage is read only by the second
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Both stages per bit
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= async_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;
endmodule

/* src/scs_top.sv */
// System time-of-day clock with pulse and message synchronisation
// Functional notes
// - Pulse sync from DI, virtual input or output
// - Rising edge rounds sync time to nearest minute
// - Add signed offset correction to sync time
// - Each sync updates the source indicator
// - No sync for 1.5 minutes: internal mode
// - Deviation is system time minus source time
// - Filter deviations, report applied adjustment
// - Learn drift, auto lead or lag correction
// - Under four seconds never step backwards
// - Interval sets 1 ms correction period, sign direction
// - Select none disables pulse sync
`timescale 1ns/10ps
module scs_top #(
    // Clock cycles per millisecond tick
    parameter int unsigned TICK_CYC = scs_pkg::MS_TICK_CYC,
    // Milliseconds without a sync before falling back to internal
    parameter logic [31:0] TMO_MS = scs_pkg::SYNC_TMO_MS
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Minute pulse inputs, asynchronous
    input wire logic pulse_di_i,
    input wire logic pulse_vi_i,
    input wire logic pulse_vo_i,
    // Configuration
    input wire logic [1:0] pulse_input_select_i,
    input wire logic signed [31:0] sync_offset_correction_i,
    // Manual time set
    input wire logic time_set_i,
    input wire logic [31:0] time_set_val_i,
    // Protocol sync message, same clock
    input wire logic msg_valid_i,
    input wire logic [31:0] msg_time_i,
    // Manual drift settings, used while internal
    input wire logic [15:0] auto_adjust_interval_i,
    input wire logic drift_sign_i,
    // Status
    output logic [31:0] sys_time_o,
    output scs_pkg::scs_src_t sync_source_indicator_o,
    output logic signed [31:0] deviation_o,
    output logic signed [31:0] filtered_deviation_o,
    output logic [15:0] auto_adjust_interval_o,
    output logic drift_sign_o,
    output logic [15:0] msg_count_o
);
    import scs_pkg::*;

    // Synchronised pulse levels and edge memory
    logic [2:0] pulse_sync;
    logic sel_lvl;
    logic sel_lvl_q;
    logic pulse_edge;
    // Millisecond prescaler
    logic [15:0] tick_cnt_q;
    logic ms_tick;
    // Time of day and slowing debt
    logic [31:0] time_q;
    logic [31:0] slow_q;
    // Sync bookkeeping
    scs_src_t src_q;
    logic [31:0] since_q;
    logic [31:0] ref_q;
    scs_src_t ref_src_q;
    logic signed [31:0] dev_q;
    logic signed [31:0] fdev_q;
    scs_state_t st_q;
    logic [15:0] cnt_q;
    // Auto-adjust
    logic [15:0] aa_int_q;
    logic aa_lead_q;
    logic [15:0] aa_sec_q;
    logic [9:0] aa_ms_q;
    logic aa_fire;

    // Wrap a millisecond value into one day
    function automatic logic [31:0] day_wrap(input logic signed [33:0] v);
        logic signed [33:0] d;
        d = $signed({2'b00, MS_PER_DAY});
        if (v < 0) day_wrap = 32'(v + d);
        else if (v >= d) day_wrap = 32'(v - d);
        else day_wrap = 32'(v);
    endfunction

    // Three pulse inputs through synchronisers
    scs_sync2 #(.W(3)) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({pulse_vo_i, pulse_vi_i, pulse_di_i}),
        .sync_o(pulse_sync)
    );

    // Input select; none forces a steady low
    always_comb begin
        case (pulse_input_select_i)
            PSEL_DI: sel_lvl = pulse_sync[0];
            PSEL_VI: sel_lvl = pulse_sync[1];
            PSEL_VO: sel_lvl = pulse_sync[2];
            default: sel_lvl = 1'b0;
        endcase
    end

    // Previous level for edge detection
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) sel_lvl_q <= 1'b0;
        else sel_lvl_q <= sel_lvl;
    end
    // One pulse per rising edge; a long high gives no repeat
    assign pulse_edge = sel_lvl & ~sel_lvl_q;

    // Millisecond tick
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || ms_tick) tick_cnt_q <= 16'h0000;
        else tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
    assign ms_tick = (tick_cnt_q == 16'(TICK_CYC - 1));

    // Reference time: rounded pulse minute or message time, plus offset
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ref_q <= TIME_RST;
            ref_src_q <= SRC_INTERNAL;
        end else if (st_q == ST_IDLE && pulse_edge) begin
            // Nearest minute: drop remainder, round up from half
            ref_q <= day_wrap(34'sd0 + $signed({2'b00,
                time_q - (time_q % MS_PER_MIN)}) +
                ((time_q % MS_PER_MIN) >= HALF_MIN_MS ?
                $signed({2'b00, MS_PER_MIN}) : 34'sd0) +
                34'(sync_offset_correction_i));
            ref_src_q <= SRC_PULSE;
        end else if (st_q == ST_IDLE && msg_valid_i) begin
            ref_q <= day_wrap($signed({2'b00, msg_time_i}) +
                34'(sync_offset_correction_i));
            ref_src_q <= SRC_PROTOCOL;
        end
    end

    // Sequencer: take, compute deviation, apply
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) st_q <= ST_IDLE;
        else begin
            case (st_q)
                ST_IDLE: if (pulse_edge || msg_valid_i) st_q <= ST_DEV;
                ST_DEV: st_q <= ST_APPLY;
                ST_APPLY: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Deviation and filtered deviation
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dev_q <= 32'sh0000_0000;
            fdev_q <= 32'sh0000_0000;
        end else if (st_q == ST_DEV) begin
            dev_q <= $signed(time_q) - $signed(ref_q);
            // Quarter of the previous deviation, clamped to +-125 ms
            if ((dev_q >>> FILT_SHIFT) > FILT_LIM_MS)
                fdev_q <= FILT_LIM_MS;
            else if ((dev_q >>> FILT_SHIFT) < -FILT_LIM_MS)
                fdev_q <= -FILT_LIM_MS;
            else
                fdev_q <= dev_q >>> FILT_SHIFT;
        end
    end

    // Auto-adjust interval in seconds, 1 ms each time it elapses
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aa_sec_q <= AA_RST;
            aa_ms_q <= 10'h000;
        end else if (ms_tick) begin
            if (aa_ms_q == 10'h3E7) begin
                aa_ms_q <= 10'h000;
                if (aa_fire) aa_sec_q <= AA_RST;
                else aa_sec_q <= aa_sec_q + 16'h0001;
            end else aa_ms_q <= aa_ms_q + 10'h001;
        end
    end
    assign aa_fire = (aa_int_q != AA_RST) &&
        (aa_sec_q + 16'h0001 >= aa_int_q) && (aa_ms_q == 10'h3E7);

    // Drift learning: external sync adapts interval, else manual
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aa_int_q <= AA_RST;
            aa_lead_q <= 1'b0;
        end else if (src_q == SRC_INTERNAL) begin
            aa_int_q <= auto_adjust_interval_i;
            aa_lead_q <= drift_sign_i;
        end else if (st_q == ST_APPLY && fdev_q != 32'sh0) begin
            // Nudge interval shorter while error persists
            aa_lead_q <= (fdev_q > 0);
            // First learned step from a zero interval sets 1000 s
            if (aa_int_q == AA_RST) aa_int_q <= 16'h03E8;
            else if (aa_int_q > 16'h0001) aa_int_q <= aa_int_q - 16'h0001;
        end
    end

    // System time: tick, slow, set, correct
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            time_q <= TIME_RST;
            slow_q <= TIME_RST;
        end else if (time_set_i) begin
            time_q <= time_set_val_i;
            slow_q <= TIME_RST;
        end else if (st_q == ST_APPLY && (dev_q >= $signed(NO_STEP_BACK_MS)
                || dev_q <= -$signed(NO_STEP_BACK_MS))) begin
            // Gross error: step straight onto the reference
            time_q <= ref_q;
            slow_q <= TIME_RST;
        end else if (st_q == ST_APPLY && fdev_q < 0) begin
            // Lagging: step forward by the filtered amount
            time_q <= day_wrap($signed({2'b00, time_q}) - 34'(fdev_q));
        end else if (st_q == ST_APPLY && fdev_q > 0) begin
            // Leading: hold back ticks instead of stepping back
            slow_q <= slow_q + 32'(fdev_q);
        end else if (ms_tick) begin
            if (aa_fire && !aa_lead_q)
                time_q <= day_wrap($signed({2'b00, time_q}) + 34'sd2);
            else if ((aa_fire && aa_lead_q) || slow_q != TIME_RST) begin
                // Skip this tick; time never runs backwards
                if (slow_q != TIME_RST && !(aa_fire && aa_lead_q))
                    slow_q <= slow_q - 32'h1;
            end else
                time_q <= day_wrap($signed({2'b00, time_q}) + 34'sd1);
        end
    end

    // Source indicator, timeout and message count
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            src_q <= SRC_INTERNAL;
            since_q <= TIME_RST;
            cnt_q <= 16'h0000;
        end else if (st_q == ST_APPLY) begin
            src_q <= ref_src_q;
            since_q <= TIME_RST;
            cnt_q <= cnt_q + 16'h0001;
        end else if (ms_tick && src_q != SRC_INTERNAL) begin
            if (since_q + 32'h1 >= TMO_MS) src_q <= SRC_INTERNAL;
            else since_q <= since_q + 32'h1;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sys_time_o <= TIME_RST;
            sync_source_indicator_o <= SRC_INTERNAL;
            deviation_o <= 32'sh0;
            filtered_deviation_o <= 32'sh0;
            auto_adjust_interval_o <= AA_RST;
            drift_sign_o <= 1'b0;
            msg_count_o <= 16'h0000;
        end else begin
            sys_time_o <= time_q;
            sync_source_indicator_o <= src_q;
            deviation_o <= dev_q;
            filtered_deviation_o <= fdev_q;
            auto_adjust_interval_o <= aa_int_q;
            drift_sign_o <= aa_lead_q;
            msg_count_o <= cnt_q;
        end
    end
endmodule

/* sim/scs_properties.sv */
// Port-level assertions for the system clock sync unit
`timescale 1ns/10ps
module scs_properties
    import scs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Watched inputs
    input wire logic msg_valid_i,
    input wire logic time_set_i,
    input wire logic [1:0] pulse_input_select_i,
    // Watched outputs
    input wire logic [31:0] sys_time_o,
    input wire scs_src_t sync_source_indicator_o,
    input wire logic signed [31:0] filtered_deviation_o,
    input wire logic [15:0] msg_count_o
);
    // One domain, so one clock and one reset for all checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Sync counter only ever moves up by one
    a_count_step: assert property ($changed(msg_count_o) |->
        msg_count_o == 16'($past(msg_count_o) + 16'h0001))
        else $error("sync count jumped");
    // A fresh message shows as protocol source within five cycles
    a_msg_source: assert property (msg_valid_i && !$past(msg_valid_i)
        && !$past(msg_valid_i, 2) && !$past(msg_valid_i, 3)
        |-> ##[1:5] sync_source_indicator_o == SRC_PROTOCOL)
        else $error("message did not set source");
    // Unused source code never appears
    a_src_legal: assert property (sync_source_indicator_o != 2'h3)
        else $error("illegal source code");
    // Applied adjustment stays inside its clamp
    a_filt_clamp: assert property (filtered_deviation_o <= FILT_LIM_MS
        && filtered_deviation_o >= -FILT_LIM_MS)
        else $error("filtered deviation out of range");
    // Small deviations never step time back; midnight wrap is large
    a_no_back: assert property (sys_time_o < $past(sys_time_o)
        && !$past(time_set_i) && !$past(time_set_i, 2)
        && !$past(time_set_i, 3)
        |-> $past(sys_time_o) - sys_time_o >= NO_STEP_BACK_MS)
        else $error("clock stepped backwards");
    // External source shown only together with a counted sync
    a_src_count: assert property ($changed(sync_source_indicator_o)
        && sync_source_indicator_o != SRC_INTERNAL
        |-> $changed(msg_count_o))
        else $error("source changed without a sync");
    // Falling back to internal never counts a sync
    a_internal_quiet: assert property ($changed(sync_source_indicator_o)
        && sync_source_indicator_o == SRC_INTERNAL |-> $stable(msg_count_o))
        else $error("internal fallback counted a sync");
    // Pulse syncs impossible with selection none
    a_none_ignored: assert property ($changed(msg_count_o)
        && sync_source_indicator_o == SRC_PULSE
        |-> pulse_input_select_i != PSEL_NONE)
        else $error("pulse sync while disabled");
    // Busy cycles after a take swallow further edges
    a_one_edge: assert property ($changed(msg_count_o)
        |=> $stable(msg_count_o) [*2])
        else $error("double sync action");

    // Main scenarios reached
    c_pulse: cover property ($changed(msg_count_o)
        && sync_source_indicator_o == SRC_PULSE);
    c_msg: cover property ($changed(msg_count_o)
        && sync_source_indicator_o == SRC_PROTOCOL);
    c_filt: cover property (filtered_deviation_o != 32'sh0000_0000);
    c_fallback: cover property ($changed(sync_source_indicator_o)
        && sync_source_indicator_o == SRC_INTERNAL);
endmodule

/* sim/scs_master.sv */
// External time master model: minute pulses and sync messages
`timescale 1ns/10ps
module scs_master #(
    parameter int HOLD_CYC = 2500000
) (
    // Bench clock, used only for pacing
    input wire logic clk_i,
    // Pulse lines: DI, virtual input, virtual output
    output logic [2:0] pulse_o,
    // Sync message
    output logic msg_valid_o,
    output logic [31:0] msg_time_o
);
    // Idle: lines low, no message
    initial begin
        pulse_o = 3'h0;
        msg_valid_o = 1'b0;
        msg_time_o = 32'h0000_0000;
    end
    // Pulse edge sent bare, no filter delay, so timing is not shifted
    task automatic send_pulse(input int idx);
        @(negedge clk_i);
        pulse_o[idx] = 1'b1;
        repeat (HOLD_CYC) @(negedge clk_i);
        pulse_o[idx] = 1'b0;
    endtask
    // One-cycle message; released data must not look like a time
    task automatic send_msg(input logic [31:0] t);
        @(negedge clk_i);
        msg_valid_o = 1'b1;
        msg_time_o = t;
        @(negedge clk_i);
        msg_valid_o = 1'b0;
        msg_time_o = ~t;
    endtask
endmodule

/* sim/tb_scs_top.sv */
// Self-checking bench for the system clock sync unit
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_scs_top;
    import scs_pkg::*;
    // Pulse table row: selection, pin driven, sync expected
    typedef struct {logic [1:0] sel; int pin; int hit;} scs_row_t;
    scs_row_t rows[5] = '{'{PSEL_DI, 0, 1}, '{PSEL_VI, 1, 1},
        '{PSEL_VO, 2, 1}, '{PSEL_NONE, 0, 0}, '{PSEL_DI, 1, 0}};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] pulse;
    logic [1:0] pulse_input_select_i = PSEL_NONE;
    logic signed [31:0] sync_offset_correction_i = 32'sh0000_0000;
    logic time_set_i = 1'b0;
    logic [31:0] time_set_val_i = 32'h0000_0000;
    logic msg_valid_i;
    logic [31:0] msg_time_i;
    logic [15:0] auto_adjust_interval_i = 16'h0001;
    logic drift_sign_i = 1'b0;
    logic [31:0] sys_time_o;
    scs_src_t sync_source_indicator_o;
    logic signed [31:0] deviation_o;
    logic signed [31:0] filtered_deviation_o;
    logic [15:0] auto_adjust_interval_o;
    logic drift_sign_o;
    logic [15:0] msg_count_o;
    logic [15:0] cnt = 16'h0000;
    logic signed [31:0] offs[2] = '{32'sh0000_01F4, 32'shFFFF_FA24};
    int checks = 0;
    int mismatches = 0;

    // 50 MHz clock
    always #10 sys_clk_i = ~sys_clk_i;

    // 50 ms hold, counted in the bench's ten-cycle millisecond
    scs_master #(.HOLD_CYC(500)) u_scs_master (.clk_i(sys_clk_i),
        .pulse_o(pulse), .msg_valid_o(msg_valid_i), .msg_time_o(msg_time_i));
    // Short millisecond and 200 ms timeout keep the run small
    scs_top #(.TICK_CYC(10), .TMO_MS(32'h0000_00C8)) u_scs_top (.sys_clk_i,
        .sys_rst_i, .pulse_di_i(pulse[0]),
        .pulse_vi_i(pulse[1]), .pulse_vo_i(pulse[2]), .pulse_input_select_i,
        .sync_offset_correction_i, .time_set_i, .time_set_val_i,
        .msg_valid_i, .msg_time_i, .auto_adjust_interval_i, .drift_sign_i,
        .sys_time_o, .sync_source_indicator_o, .deviation_o,
        .filtered_deviation_o, .auto_adjust_interval_o, .drift_sign_o,
        .msg_count_o);

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Load a time of day, then let it settle
    task automatic set_time(input logic [31:0] t);
        @(negedge sys_clk_i);
        time_set_i = 1'b1;
        time_set_val_i = t;
        @(negedge sys_clk_i);
        time_set_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
    endtask

    // Watchdog, far beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        `CHK(msg_count_o, 16'h0000)
        $display("reset test done");
        // Lagging 5 s before a minute: pulse rounds up to the minute
        set_time(32'h0009_1438);
        pulse_input_select_i = PSEL_DI;
        // Checked while the pulse still stands, before time runs on
        fork
            u_scs_master.send_pulse(0);
            begin
                repeat (8) @(negedge sys_clk_i);
                `CHK($unsigned(sys_time_o - 32'h927C0) <= 32'h1, 1'b1)
                `CHK($unsigned(deviation_o + 32'sh1388) <= 32'h1, 1'b1)
            end
        join
        // Let the released pin flush through the synchroniser
        repeat (4) @(negedge sys_clk_i);
        cnt++;
        $display("rounding test done");
        // Table of selections against driven pins
        foreach (rows[i]) begin
            pulse_input_select_i = rows[i].sel;
            cnt = cnt + 16'(rows[i].hit);
            fork
                u_scs_master.send_pulse(rows[i].pin);
                begin
                    repeat (8) @(negedge sys_clk_i);
                    `CHK(msg_count_o, cnt)
                    `CHK(sync_source_indicator_o, SRC_PULSE)
                end
            join
            // A still-high old pin must not meet the next selection
            repeat (4) @(negedge sys_clk_i);
        end
        $display("pulse table done");
        // Messages with positive and negative offset
        pulse_input_select_i = PSEL_NONE;
        foreach (offs[i]) begin
            sync_offset_correction_i = offs[i];
            set_time(32'h000F_4240);
            u_scs_master.send_msg(32'h000F_4240);
            repeat (8) @(negedge sys_clk_i);
            cnt++;
            `CHK(msg_count_o, cnt)
            `CHK(sync_source_indicator_o, SRC_PROTOCOL)
            `CHK($unsigned(deviation_o + offs[i]) <= 32'h1, 1'b1)
        end
        // Previous 500 ms lag quarters to the -125 ms limit; lagging sets the sign to lag
        `CHK(filtered_deviation_o, 32'shFFFF_FF83)
        `CHK(drift_sign_o, 1'b0)
        $display("offset test done");
        // Second message inside the busy window is dropped
        u_scs_master.send_msg(32'h000F_4240);
        u_scs_master.send_msg(32'h000F_4240);
        repeat (8) @(negedge sys_clk_i);
        cnt++;
        `CHK(msg_count_o, cnt)
        // Previous 1500 ms lead clamps; leading sets the sign to lead
        `CHK(filtered_deviation_o, 32'sh0000_007D)
        `CHK(drift_sign_o, 1'b1)
        $display("back to back test done");
        // Reset in mid-run clears source and count
        sys_rst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        `CHK(sync_source_indicator_o, SRC_INTERNAL)
        `CHK(msg_count_o, 16'h0000)
        sys_rst_i = 1'b0;
        // Internal mode runs on the manual drift settings
        auto_adjust_interval_i = 16'h000A;
        drift_sign_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        `CHK(auto_adjust_interval_o, 16'h000A)
        `CHK(drift_sign_o, 1'b1)
        u_scs_master.send_msg(32'h000F_4240);
        repeat (8) @(negedge sys_clk_i);
        `CHK(msg_count_o, 16'h0001)
        `CHK(sync_source_indicator_o, SRC_PROTOCOL)
        $display("mid-run reset test done");
        // Silence: source holds at 150 ms, internal well past 200 ms
        repeat (1500) @(negedge sys_clk_i);
        `CHK(sync_source_indicator_o, SRC_PROTOCOL)
        repeat (1000) @(negedge sys_clk_i);
        `CHK(sync_source_indicator_o, SRC_INTERNAL)
        `CHK(msg_count_o, 16'h0001)
        $display("timeout test done");
        finish_test();
    end
endmodule

bind scs_top scs_properties u_scs_properties (.sys_clk_i, .sys_rst_i,
    .msg_valid_i, .time_set_i, .pulse_input_select_i, .sys_time_o,
    .sync_source_indicator_o, .filtered_deviation_o, .msg_count_o);
